// ===== common/icu_regs.svh
// Function
// - sign-extend immediate to 32 bits for compare
// - equal-immediate writes one or zero, no exception
// - signed register compare, greater or equal
// - signed immediate compare, greater or equal
// - unsigned register compare, greater or equal
// - opcode 0x20 is equal-immediate
// - opcode 0x08 is signed ge-immediate
// - opcode 0x3a, zero shift, ext 0x08/0x28
// - operand fields index general registers
`ifndef ICU_REGS_SVH
`define ICU_REGS_SVH
`define ICU_A_HI 31
`define ICU_A_LO 27
`define ICU_B_HI 26
`define ICU_B_LO 22
`define ICU_C_HI 21
`define ICU_C_LO 17
`define ICU_IMM_HI 21
`define ICU_IMM_LO 6
`define ICU_OPX_HI 16
`define ICU_OPX_LO 11
`define ICU_SH_HI 10
`define ICU_SH_LO 6
`define ICU_OP_HI 5
`define ICU_OP_LO 0
`define ICU_OP_CMPEQI 6'h20
`define ICU_OP_CMPGEI 6'h08
`define ICU_OP_RTYPE 6'h3a
`define ICU_OPX_CMPGE 6'h08
`define ICU_OPX_CMPGEU 6'h28
`define ICU_SH_ZERO 5'h00
`endif

// ===== common/icu_pkg.sv
package icu_pkg;
  typedef enum logic [2:0] {
    ICU_NONE, ICU_EQI, ICU_GEI, ICU_GE, ICU_GEU
  } icu_op_type;
endpackage

// ===== logic/icu_decode.sv
`timescale 1ns/1ps
`include "icu_regs.svh"
module icu_decode (
  input wire logic [31:0] instr,
  output icu_pkg::icu_op_type op,
  output logic [4:0] dest_idx
);
  logic [5:0] opc;
  logic [5:0] opx;
  logic [4:0] sh;
  assign opc = instr[`ICU_OP_HI:`ICU_OP_LO];
  assign opx = instr[`ICU_OPX_HI:`ICU_OPX_LO];
  assign sh = instr[`ICU_SH_HI:`ICU_SH_LO];
  always_comb
  begin
    op = icu_pkg::ICU_NONE;
    dest_idx = instr[`ICU_B_HI:`ICU_B_LO];
    if (opc == `ICU_OP_CMPEQI)
      op = icu_pkg::ICU_EQI;
    else if (opc == `ICU_OP_CMPGEI)
      op = icu_pkg::ICU_GEI;
    else if (opc == `ICU_OP_RTYPE && sh == `ICU_SH_ZERO)
    begin
      dest_idx = instr[`ICU_C_HI:`ICU_C_LO];
      if (opx == `ICU_OPX_CMPGE)
        op = icu_pkg::ICU_GE;
      else if (opx == `ICU_OPX_CMPGEU)
        op = icu_pkg::ICU_GEU;
    end
  end
endmodule

// ===== logic/icu_top.sv
`timescale 1ns/1ps
`include "icu_regs.svh"
module icu_top (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR,
  input wire logic [31:0] SRC_A_DATA,
  input wire logic [31:0] SRC_B_DATA,
  output logic [4:0] SRC_A_IDX,
  output logic [4:0] SRC_B_IDX,
  output logic WR_EN,
  output logic [4:0] WR_IDX,
  output logic [31:0] WR_DATA
);
  ////////////////////////////////////////////////////////////////////////
  // decoded operation and operands
  icu_pkg::icu_op_type op;
  logic [4:0] dest_idx;
  logic [4:0] fld_a;
  logic [4:0] fld_b;
  logic [15:0] fld_imm;
  logic [31:0] imm_ext;
  logic [31:0] opnd_b;
  logic hit;
  logic op_known;

  ////////////////////////////////////////////////////////////////////////
  // registered state and next values
  logic [4:0] a_idx_r;
  logic [4:0] a_idx_nxt;
  logic [4:0] b_idx_r;
  logic [4:0] b_idx_nxt;

  logic we_r;
  logic we_nxt;
  logic [4:0] wi_r;
  logic [4:0] wi_nxt;

  logic [31:0] wd_r;
  logic [31:0] wd_nxt;

  ////////////////////////////////////////////////////////////////////////
  // helper functions
  function automatic logic [31:0] sext16(
    input logic [15:0] v
  );
    sext16 = {{16{v[15]}}, v};
  endfunction

  function automatic logic ge_signed(
    input logic [31:0] x,
    input logic [31:0] y
  );
    ge_signed = ($signed(x) >= $signed(y));
  endfunction

  function automatic logic ge_unsigned(
    input logic [31:0] x,
    input logic [31:0] y
  );
    ge_unsigned = (x >= y);
  endfunction

  function automatic logic is_imm_op(
    input icu_pkg::icu_op_type o
  );
    is_imm_op = (o == icu_pkg::ICU_EQI) || (o == icu_pkg::ICU_GEI);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // instruction fields
  assign fld_a = INSTR[`ICU_A_HI:`ICU_A_LO];
  assign fld_b = INSTR[`ICU_B_HI:`ICU_B_LO];
  assign fld_imm = INSTR[`ICU_IMM_HI:`ICU_IMM_LO];

  ////////////////////////////////////////////////////////////////////////
  // instruction decode
  icu_decode u_icu_decode (
    .instr(INSTR),
    .op(op),
    .dest_idx(dest_idx)
  );

  ////////////////////////////////////////////////////////////////////////
  // operand selection, immediates replace the second register
  always_comb
  begin
    imm_ext = sext16(fld_imm);
    if (is_imm_op(op))
    begin
      opnd_b = imm_ext;
    end
    else
    begin
      opnd_b = SRC_B_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare
  always_comb
  begin
    hit = 1'b0;
    op_known = 1'b1;
    unique case (op)
      icu_pkg::ICU_NONE:
      begin
        hit = 1'b0;
        op_known = 1'b0;
      end
      icu_pkg::ICU_EQI:
      begin
        hit = (SRC_A_DATA == opnd_b);
      end
      icu_pkg::ICU_GEI:
      begin
        hit = ge_signed(SRC_A_DATA, opnd_b);
      end
      icu_pkg::ICU_GE:
      begin
        hit = ge_signed(SRC_A_DATA, opnd_b);
      end
      icu_pkg::ICU_GEU:
      begin
        hit = ge_unsigned(SRC_A_DATA, opnd_b);
      end
      default:
      begin
        hit = 1'b0;
        op_known = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // operand index group
  always_comb
  begin
    a_idx_nxt = fld_a;
    b_idx_nxt = fld_b;
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      a_idx_r <= 5'h00;
      b_idx_r <= 5'h00;
    end
    else
    begin
      a_idx_r <= a_idx_nxt;
      b_idx_r <= b_idx_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write enable group
  always_comb
  begin
    we_nxt = 1'b0;
    if (INSTR_VALID && op_known)
    begin
      we_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      we_r <= 1'b0;
    end
    else
    begin
      we_r <= we_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write index group
  always_comb
  begin
    wi_nxt = dest_idx;
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      wi_r <= 5'h00;
    end
    else
    begin
      wi_r <= wi_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write data group
  always_comb
  begin
    wd_nxt = 32'h0;
    if (hit)
    begin
      wd_nxt = 32'h1;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      wd_r <= 32'h0;
    end
    else
    begin
      wd_r <= wd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the registers
  assign SRC_A_IDX = a_idx_r;
  assign SRC_B_IDX = b_idx_r;
  assign WR_EN = we_r;
  assign WR_IDX = wi_r;
  assign WR_DATA = wd_r;
endmodule

// ===== sim/icu_rf_model.sv
`timescale 1ns/1ps
module icu_rf_model (
  input wire logic [31:0] INSTR,
  output logic [31:0] SRC_A_DATA,
  output logic [31:0] SRC_B_DATA
);
  logic [31:0] rf [32] = '{default: 32'h0};
  assign SRC_A_DATA = rf[INSTR[31:27]];
  assign SRC_B_DATA = rf[INSTR[26:22]];
endmodule

// ===== sim/icu_checker.sv
`timescale 1ns/1ps
module icu_checker (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR,
  input wire logic [31:0] SRC_A_DATA,
  input wire logic [31:0] SRC_B_DATA,
  input wire logic [4:0] SRC_A_IDX,
  input wire logic WR_EN,
  input wire logic [4:0] WR_IDX,
  input wire logic [31:0] WR_DATA
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  logic rt_ok;
  assign rt_ok = INSTR_VALID && INSTR[5:0] == 6'h3a && INSTR[10:6] == 5'h0;
  property p_ge;
    rt_ok && INSTR[16:11] == 6'h08
    |=> WR_EN && WR_IDX == $past(INSTR[21:17])
    && WR_DATA[0] ==
      ($signed($past(SRC_A_DATA)) >= $signed($past(SRC_B_DATA)));
  endproperty
  a_ge: assert property (p_ge) else $error("signed compare");
  property p_geu;
    rt_ok && INSTR[16:11] == 6'h28
    |=> WR_EN && WR_IDX == $past(INSTR[21:17])
    && WR_DATA[0] == ($past(SRC_A_DATA) >= $past(SRC_B_DATA));
  endproperty
  a_geu: assert property (p_geu) else $error("unsigned");
  property p_eq;
    INSTR_VALID && INSTR[5:0] == 6'h20
    && SRC_A_DATA == {{16{INSTR[21]}}, INSTR[21:6]}
    |=> WR_DATA == 32'h1;
  endproperty
  a_eq: assert property (p_eq) else $error("equal imm");
  property p_wd; WR_EN |-> WR_DATA[31:1] == 31'h0; endproperty
  a_wd: assert property (p_wd) else $error("upper bits");
  property p_ai; 1'b1 |=> SRC_A_IDX == $past(INSTR[31:27]); endproperty
  a_ai: assert property (p_ai) else $error("a index");
  property p_nv; !INSTR_VALID |=> !WR_EN; endproperty
  a_nv: assert property (p_nv) else $error("stray write");
  property p_sh; INSTR[5:0] == 6'h3a && INSTR[10:6] != 5'h0 |=> !WR_EN;
  endproperty
  a_sh: assert property (p_sh) else $error("shift");
  property p_im; INSTR_VALID && INSTR[5:0] inside {6'h20, 6'h08}
    |=> WR_EN && WR_IDX == $past(INSTR[26:22]); endproperty
  a_im: assert property (p_im) else $error("imm");
endmodule
bind icu_top icu_checker u_icu_checker (
  .CLOCK(CLOCK),
  .NRST(NRST),
  .INSTR_VALID(INSTR_VALID),
  .INSTR(INSTR),
  .SRC_A_DATA(SRC_A_DATA),
  .SRC_B_DATA(SRC_B_DATA),
  .SRC_A_IDX(SRC_A_IDX),
  .WR_EN(WR_EN),
  .WR_IDX(WR_IDX),
  .WR_DATA(WR_DATA)
);

// ===== sim/icu_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, x, y) \
  begin \
    comparisons++; \
    fails += ((y) !== (x)); \
    if ((y) !== (x)) $display("MISMATCH %s exp %h got %h", n, x, y); \
  end
module icu_top_tb;
  logic CLOCK = 1'h0, NRST = 1'h0, INSTR_VALID = 1'h0, e;
  logic [31:0] INSTR = 32'h0, i, a, b;
  logic [4:0] w;
  wire WR_EN;
  wire [4:0] SRC_A_IDX, SRC_B_IDX, WR_IDX;
  wire [31:0] SRC_A_DATA, SRC_B_DATA, WR_DATA;
  int fails = 0, comparisons = 0;
  logic [101:0] rows [10] = '{
    {32'h08bfffe0, 32'hffffffff, 32'h0, 5'h02, 1'h1},
    {32'h08bfffe0, 32'h0000ffff, 32'h0, 5'h02, 1'h0},
    {32'h08a00008, 32'h80000000, 32'h0, 5'h02, 1'h0},
    {32'h08a00008, 32'hffff8000, 32'h0, 5'h02, 1'h1},
    {32'h08801908, 32'h00000064, 32'h0, 5'h02, 1'h1},
    {32'h08801920, 32'h00000064, 32'h0, 5'h02, 1'h1},
    {32'h0886403a, 32'hffffffff, 32'h1, 5'h03, 1'h0},
    {32'h0886403a, 32'h00000005, 32'h5, 5'h03, 1'h1},
    {32'h0887403a, 32'h00000000, 32'h1, 5'h03, 1'h0},
    {32'h0887403a, 32'hffffffff, 32'h1, 5'h03, 1'h1}};
  icu_top u_icu_top (.*);
  icu_rf_model u_icu_rf_model (.*);
  initial forever #10 CLOCK = ~CLOCK;
  task automatic wrap_up;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge CLOCK);
    NRST <= 1'h1;
    foreach (rows[k])
    begin
      {i, a, b, w, e} = rows[k];
      @(posedge CLOCK);
      INSTR <= i;
      INSTR_VALID <= 1'h1;
      u_icu_rf_model.rf[1] <= a;
      u_icu_rf_model.rf[2] <= b;
      @(posedge CLOCK);
      #1;
      `CHK("en", 1'h1, WR_EN)
      `CHK("data", {31'h0, e}, WR_DATA)
      `CHK("idx", w, WR_IDX)
      `CHK("a_idx", i[31:27], SRC_A_IDX)
      `CHK("b_idx", i[26:22], SRC_B_IDX)
      $display("row %0d done", k);
    end
    @(posedge CLOCK);
    INSTR <= 32'h0886407a;
    @(posedge CLOCK);
    #1;
    `CHK("shift", 1'h0, WR_EN)
    $display("shift done");
    @(posedge CLOCK);
    INSTR <= 32'h0887003a;
    @(posedge CLOCK);
    #1;
    `CHK("opx", 1'h0, WR_EN)
    $display("opx done");
    @(posedge CLOCK);
    INSTR <= 32'h08801908;
    INSTR_VALID <= 1'h0;
    @(posedge CLOCK);
    #1;
    `CHK("idle", 1'h0, WR_EN)
    $display("idle done");
    @(posedge CLOCK);
    INSTR_VALID <= 1'h1;
    u_icu_rf_model.rf[1] <= 32'h00000064;
    @(posedge CLOCK);
    NRST <= 1'h0;
    #1;
    `CHK("rst_en", 1'h0, WR_EN)
    `CHK("rst_data", 32'h0, WR_DATA)
    `CHK("rst_idx", 5'h00, WR_IDX)
    `CHK("rst_a_idx", 5'h00, SRC_A_IDX)
    @(posedge CLOCK);
    NRST <= 1'h1;
    #1;
    `CHK("rel_en", 1'h0, WR_EN)
    @(posedge CLOCK);
    #1;
    `CHK("run_en", 1'h1, WR_EN)
    `CHK("run_data", 32'h1, WR_DATA)
    `CHK("run_idx", 5'h02, WR_IDX)
    $display("reset done");
    wrap_up();
  end
endmodule
